// ===== src/hec_encoder.sv
// Hopping encoder control: wake, debounce, counter update, cipher, send.
// Assumes switch, data and supply-comparator inputs are synchronous to i_core_clk.
`timescale 1ns/100ps

module hec_encoder
    import hec_pkg::*;
#(
    parameter logic [31:0] DEBOUNCE_CYCLES = 32'(DEBOUNCE_CYC),
    parameter logic [39:0] SHUTOFF_CYCLES = 40'(SHUTOFF_CYC),
    parameter logic [31:0] ELEM_SLOW_CYCLES = 32'(ELEM_SLOW_CYC),
    parameter logic [31:0] ELEM_MID_CYCLES = 32'(ELEM_MID_CYC),
    parameter logic [31:0] ELEM_FAST_CYCLES = 32'(ELEM_FAST_CYC),
    parameter int BUF_DEPTH = 2
) (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Switches and programming
    input wire logic [3:0] i_switch_in,
    input wire logic i_prog_mode,
    input wire logic i_pwm,
    // Supply comparators
    input wire logic i_supply_below_6v,
    input wire logic i_supply_below_9v,
    // Modulated pin and indicator
    output logic o_pwm,
    output logic o_pwm_oe,
    output logic o_led_n,
    // Status
    output logic o_awake,
    output logic o_timeout
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    hec_state_t state_q;
    logic [15:0] nv_q [NV_WORDS];
    logic [31:0] deb_cnt_q;
    logic [39:0] shut_cnt_q;
    logic [9:0] round_q;
    logic [31:0] hop_q;
    logic [31:0] fixed_q;
    logic [3:0] btn_q;
    logic repeat_q;
    logic [3:0] prev_sw_q;
    logic [15:0] prog_shift_q;
    logic [3:0] prog_bits_q;
    logic [3:0] prog_addr_q;
    hec_code_word_t buf_q [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] count_q;
    hec_code_word_t ser_word_q;
    logic ser_active_q;
    logic ser_blank_q;
    logic ser_done_q;
    logic [6:0] ser_bit_q;
    logic [1:0] ser_phase_q;
    logic [7:0] ser_guard_q;
    logic [31:0] ser_elem_q;
    logic [1:0] word_idx_q;
    logic [63:0] key;
    logic [15:0] opt;
    logic [31:0] serial;
    logic sending;
    logic new_press;
    logic shut_hit;
    logic flush;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic prog_edge;
    logic [31:0] elem_len;
    hec_rate_t rate;
    hec_plain_t plain;

    // ------------------------------------------------------------
    // Decoded store fields
    // ------------------------------------------------------------
    // key from words
    assign key = {nv_q[ADDR_KEY3], nv_q[ADDR_KEY2], nv_q[ADDR_KEY1], nv_q[ADDR_KEY0]};
    assign opt = nv_q[ADDR_OPTION];
    assign serial = {nv_q[ADDR_SERIAL_HI], nv_q[ADDR_SERIAL_LO]};
    assign rate = hec_rate_t'({opt[OPT_RATE_HI], opt[OPT_RATE_LO]});
    assign plain.btn = btn_q;
    assign plain.wrap_second = opt[OPT_WRAP_SECOND];
    assign plain.wrap_first = opt[OPT_WRAP_FIRST];
    assign plain.check = opt[OPT_CHECK_LSB +: OPT_CHECK_W];
    assign plain.count = nv_q[ADDR_HOP_CNT];

    // Word is in flight from cipher start to last guard element
    assign sending = (state_q == ST_HOP) || (state_q == ST_OUTER)
        || (state_q == ST_PUSH) || (state_q == ST_SEND);
    assign new_press = sending && ((i_switch_in & ~btn_q) != 4'h0);
    assign shut_hit = serial[16 + SER_SHUTOFF_BIT] && (shut_cnt_q >= SHUTOFF_CYCLES - 40'h1);
    assign flush = (sending || state_q == ST_DEBOUNCE) && (new_press || shut_hit);
    // programming clock on switch 3 or 2
    assign prog_edge = (i_switch_in[3] && !prev_sw_q[3]) || (i_switch_in[2] && !prev_sw_q[2]);

    always_comb begin
        case (rate)
            RATE_ALL: elem_len = ELEM_SLOW_CYCLES;
            RATE_HALF_MID: elem_len = ELEM_MID_CYCLES;
            default: elem_len = ELEM_FAST_CYCLES;
        endcase
    end

    // ------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q <= ST_STANDBY;
            deb_cnt_q <= 32'h0;
            round_q <= 10'h0;
            btn_q <= 4'h0;
            repeat_q <= 1'b0;
        end else if (i_ce) begin
            if (flush) begin
                if (shut_hit) begin
                    state_q <= ST_TIMEOUT;
                end else begin
                    state_q <= ST_DEBOUNCE;
                    deb_cnt_q <= 32'h0;
                end
            end else begin
                case (state_q)
                    ST_STANDBY: begin
                        repeat_q <= 1'b0;
                        if (i_prog_mode) begin
                            state_q <= ST_PROG;
                        end else if (i_switch_in != 4'h0) begin
                            state_q <= ST_DEBOUNCE;
                            deb_cnt_q <= 32'h0;
                        end
                    end
                    ST_DEBOUNCE: begin
                        if (deb_cnt_q >= DEBOUNCE_CYCLES - 32'h1) begin
                            btn_q <= i_switch_in;
                            state_q <= (i_switch_in == 4'h0) ? ST_STANDBY : ST_UPDATE;
                        end else begin
                            deb_cnt_q <= deb_cnt_q + 32'h1;
                        end
                    end
                    ST_UPDATE: begin
                        round_q <= 10'h0;
                        if (btn_q == 4'hf) begin
                            hop_q <= {nv_q[ADDR_LEARN_HI], nv_q[ADDR_LEARN_LO]};
                            fixed_q <= {btn_q, serial[SER_TX_BITS-1:0]};
                            state_q <= ST_PUSH;
                        end else begin
                            state_q <= ST_HOP;
                        end
                    end
                    ST_HOP: begin
                        if (round_q == 10'h0) begin
                            hop_q <= plain;
                        end else begin
                            hop_q <= hec_round(hop_q, key[6'(round_q - 10'h1)]);
                        end
                        if (round_q == 10'(HOP_ROUNDS)) begin
                            round_q <= 10'h0;
                            fixed_q <= {btn_q, serial[SER_TX_BITS-1:0]};
                            state_q <= opt[OPT_OUTER_EN] ? ST_OUTER : ST_PUSH;
                        end else begin
                            round_q <= round_q + 10'h1;
                        end
                    end
                    ST_OUTER: begin
                        fixed_q <= hec_round(fixed_q, nv_q[ADDR_OUTER_KEY][round_q[3:0]]);
                        if (round_q == 10'(OUTER_ROUNDS - 1)) begin
                            state_q <= ST_PUSH;
                        end
                        round_q <= round_q + 10'h1;
                    end
                    ST_PUSH: begin
                        if (buf_in_ready) begin
                            state_q <= ST_SEND;
                        end
                    end
                    ST_SEND: begin
                        if (ser_done_q) begin
                            repeat_q <= 1'b1;
                            state_q <= (i_switch_in == 4'h0) ? ST_STANDBY : ST_UPDATE;
                        end
                    end
                    ST_TIMEOUT: begin
                        if (i_switch_in == 4'h0) begin
                            state_q <= ST_STANDBY;
                        end
                    end
                    ST_PROG: begin
                        if (!i_prog_mode) begin
                            state_q <= ST_STANDBY;
                        end
                    end
                    default: state_q <= ST_STANDBY;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Auto-shutoff timer
    // ------------------------------------------------------------
    // counts while held
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            shut_cnt_q <= 40'h0;
        end else if (i_ce) begin
            if (i_switch_in == 4'h0 || state_q == ST_STANDBY || state_q == ST_PROG) begin
                shut_cnt_q <= 40'h0;
            end else if (!shut_hit) begin
                shut_cnt_q <= shut_cnt_q + 40'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Nonvolatile store and programming
    // ------------------------------------------------------------
    // twelve words, addressed by index
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            for (int i = 0; i < NV_WORDS; i++) begin
                nv_q[i] <= NV_RESET;
            end
        end else if (i_ce) begin
            if (state_q == ST_PROG && prog_edge && prog_bits_q == 4'hf) begin
                // word shifted in from data pin
                if (prog_addr_q != ADDR_UNUSED) begin
                    nv_q[prog_addr_q] <= {i_pwm, prog_shift_q[15:1]};
                end
            end else if (state_q == ST_UPDATE && !flush && btn_q != 4'hf) begin
                nv_q[ADDR_HOP_CNT] <= nv_q[ADDR_HOP_CNT] + 16'h1;
                // wrap clears flags in turn; only ever cleared
                if (nv_q[ADDR_HOP_CNT] == 16'hffff) begin
                    if (opt[OPT_WRAP_FIRST]) begin
                        nv_q[ADDR_OPTION][OPT_WRAP_FIRST] <= 1'b0;
                    end else begin
                        nv_q[ADDR_OPTION][OPT_WRAP_SECOND] <= 1'b0;
                    end
                end
            end
        end
    end

    // Programming shift register; LSB of each word arrives first
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prev_sw_q <= 4'h0;
            prog_shift_q <= 16'h0;
            prog_bits_q <= 4'h0;
            prog_addr_q <= 4'h0;
        end else if (i_ce) begin
            prev_sw_q <= i_switch_in;
            if (state_q != ST_PROG) begin
                prog_bits_q <= 4'h0;
                prog_addr_q <= 4'h0;
            end else if (prog_edge) begin
                prog_shift_q <= {i_pwm, prog_shift_q[15:1]};
                prog_bits_q <= prog_bits_q + 4'h1;
                if (prog_bits_q == 4'hf && prog_addr_q != ADDR_OPTION) begin
                    prog_addr_q <= prog_addr_q + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Two-entry word buffer
    // ------------------------------------------------------------
    // Lets a finished word wait while the serializer still drains the last
    assign buf_in_valid = (state_q == ST_PUSH) && !flush;
    assign buf_in_ready = (count_q != (PTR_W+1)'(BUF_DEPTH));
    assign buf_out_valid = (count_q != '0);
    assign buf_out_ready = !ser_active_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else if (i_ce) begin
            if (flush) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
                count_q <= '0;
            end else begin
                if (buf_in_valid && buf_in_ready) begin
                    buf_q[wr_ptr_q] <= '{opt[OPT_SUPPLY_TRIP] ? i_supply_below_9v
                        : i_supply_below_6v, repeat_q, fixed_q, hop_q};
                    wr_ptr_q <= (wr_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
                end
                if (buf_out_valid && buf_out_ready) begin
                    rd_ptr_q <= (rd_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
                end
                count_q <= count_q + (PTR_W+1)'(buf_in_valid && buf_in_ready)
                    - (PTR_W+1)'(buf_out_valid && buf_out_ready);
            end
        end
    end

    // ------------------------------------------------------------
    // Serializer
    // ------------------------------------------------------------
    // Each bit is high, inverted data, low; a guard gap closes the word
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            ser_active_q <= 1'b0;
            ser_blank_q <= 1'b0;
            ser_done_q <= 1'b0;
            ser_bit_q <= 7'h0;
            ser_phase_q <= 2'h0;
            ser_guard_q <= 8'h0;
            ser_elem_q <= 32'h0;
            word_idx_q <= 2'h0;
            ser_word_q <= '0;
        end else if (i_ce) begin
            ser_done_q <= 1'b0;
            if (flush) begin
                ser_active_q <= 1'b0;
            end else if (!ser_active_q) begin
                if (state_q == ST_STANDBY) begin
                    word_idx_q <= 2'h0;
                end
                if (buf_out_valid) begin
                    ser_word_q <= buf_q[rd_ptr_q];
                    ser_active_q <= 1'b1;
                    ser_blank_q <= (rate == RATE_QUARTER) ? (word_idx_q != 2'h0)
                        : (rate != RATE_ALL) && word_idx_q[0];
                    word_idx_q <= word_idx_q + 2'h1;
                    ser_bit_q <= 7'h0;
                    ser_phase_q <= 2'h0;
                    ser_guard_q <= 8'h0;
                    ser_elem_q <= 32'h0;
                end
            end else if (ser_elem_q < elem_len - 32'h1) begin
                ser_elem_q <= ser_elem_q + 32'h1;
            end else begin
                ser_elem_q <= 32'h0;
                if (ser_bit_q < 7'(WORD_BITS)) begin
                    if (ser_phase_q == 2'(ELEMS_PER_BIT - 1)) begin
                        ser_phase_q <= 2'h0;
                        ser_bit_q <= ser_bit_q + 7'h1;
                    end else begin
                        ser_phase_q <= ser_phase_q + 2'h1;
                    end
                end else if (ser_guard_q == 8'(GUARD_ELEMS - 1)) begin
                    ser_active_q <= 1'b0;
                    ser_done_q <= 1'b1;
                end else begin
                    ser_guard_q <= ser_guard_q + 8'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registered pins
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_pwm <= 1'b0;
            o_pwm_oe <= 1'b0;
            o_led_n <= 1'b1;
            o_awake <= 1'b0;
            o_timeout <= 1'b0;
        end else if (i_ce) begin
            o_pwm_oe <= (state_q != ST_PROG);
            if (!ser_active_q || flush || ser_blank_q || ser_bit_q >= 7'(WORD_BITS)) begin
                o_pwm <= 1'b0;
            end else begin
                o_pwm <= (ser_phase_q == 2'h0)
                    || (ser_phase_q == 2'h1 && !ser_word_q[ser_bit_q]);
            end
            o_led_n <= !(ser_active_q && !flush);
            o_awake <= (state_q != ST_STANDBY);
            o_timeout <= (state_q == ST_TIMEOUT);
        end
    end

endmodule : hec_encoder

// ===== src/hec_pkg.sv
// Shared constants, types and the round function of the hopping encoder.
// Assumes a 250 MHz core clock; the debounce, shutoff and element counts below are derived from it.
package hec_pkg;

    // ------------------------------------------------------------
    // Nonvolatile store layout
    // ------------------------------------------------------------
    localparam int NV_WORDS = 12;
    localparam int NV_WIDTH = 16;
    localparam logic [3:0] ADDR_KEY0 = 4'h0;
    localparam logic [3:0] ADDR_KEY1 = 4'h1;
    localparam logic [3:0] ADDR_KEY2 = 4'h2;
    localparam logic [3:0] ADDR_KEY3 = 4'h3;
    localparam logic [3:0] ADDR_HOP_CNT = 4'h4;
    localparam logic [3:0] ADDR_UNUSED = 4'h5;
    localparam logic [3:0] ADDR_SERIAL_LO = 4'h6;
    localparam logic [3:0] ADDR_SERIAL_HI = 4'h7;
    localparam logic [3:0] ADDR_LEARN_LO = 4'h8;
    localparam logic [3:0] ADDR_LEARN_HI = 4'h9;
    localparam logic [3:0] ADDR_OUTER_KEY = 4'ha;
    localparam logic [3:0] ADDR_OPTION = 4'hb;
    localparam logic [15:0] NV_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Option word and serial fields
    // ------------------------------------------------------------
    localparam int OPT_CHECK_LSB = 0;
    localparam int OPT_CHECK_W = 10;
    localparam int OPT_WRAP_FIRST = 10;
    localparam int OPT_WRAP_SECOND = 11;
    localparam int OPT_SUPPLY_TRIP = 12;
    localparam int OPT_RATE_LO = 13;
    localparam int OPT_RATE_HI = 14;
    localparam int OPT_OUTER_EN = 15;
    localparam int SER_SHUTOFF_BIT = 15;
    localparam int SER_TX_BITS = 28;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
    localparam longint SHUTOFF_S = 25;
    localparam longint SHUTOFF_CYC = SHUTOFF_S * 1000000 * CLK_MHZ;
    localparam int ELEM_SLOW_US = 400;
    localparam int ELEM_MID_US = 200;
    localparam int ELEM_FAST_US = 100;
    localparam int ELEM_SLOW_CYC = ELEM_SLOW_US * CLK_MHZ;
    localparam int ELEM_MID_CYC = ELEM_MID_US * CLK_MHZ;
    localparam int ELEM_FAST_CYC = ELEM_FAST_US * CLK_MHZ;
    localparam int WORD_BITS = 66;
    localparam int ELEMS_PER_BIT = 3;
    localparam int GUARD_ELEMS = 30;
    localparam int HOP_ROUNDS = 528;
    localparam int OUTER_ROUNDS = 32;
    // Arbitrary nonlinear table; any 32-bit value works for the structure
    localparam logic [31:0] NLF_TABLE = 32'h6b1d94e3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_ALL = 2'b00,
        RATE_HALF_MID = 2'b01,
        RATE_HALF_FAST = 2'b10,
        RATE_QUARTER = 2'b11
    } hec_rate_t;

    typedef enum logic [3:0] {
        ST_STANDBY = 4'b0000,
        ST_DEBOUNCE = 4'b0001,
        ST_UPDATE = 4'b0010,
        ST_HOP = 4'b0011,
        ST_OUTER = 4'b0100,
        ST_PUSH = 4'b0101,
        ST_SEND = 4'b0110,
        ST_TIMEOUT = 4'b0111,
        ST_PROG = 4'b1000
    } hec_state_t;

    typedef struct packed {
        logic [3:0] btn;
        logic wrap_second;
        logic wrap_first;
        logic [9:0] check;
        logic [15:0] count;
    } hec_plain_t;

    typedef struct packed {
        logic low_supply;
        logic repeat_word;
        logic [31:0] fixed;
        logic [31:0] hop;
    } hec_code_word_t;

    // One shift round of the nonlinear feedback cipher
    function automatic logic [31:0] hec_round(input logic [31:0] x, input logic kbit);
        logic [4:0] idx;
        logic fb;
        idx = {x[31], x[26], x[20], x[9], x[1]};
        fb = NLF_TABLE[idx] ^ x[16] ^ x[0] ^ kbit;
        return {fb, x[31:1]};
    endfunction : hec_round

endpackage : hec_pkg

// ===== test/hec_encoder_sva.sv
// Port checker for the hopping encoder.
// Assumes it is bound onto hec_encoder and i_ce drops only while switches are steady.
`timescale 1ns/100ps
module hec_encoder_chk (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Watched ports
    input wire logic [3:0] i_switch_in,
    input wire logic i_prog_mode,
    input wire logic o_pwm,
    input wire logic o_pwm_oe,
    input wire logic o_led_n,
    input wire logic o_awake,
    input wire logic o_timeout
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // A switch joins the held set while the word is on air
    sequence s_added; !o_led_n && |(i_switch_in & ~$past(i_switch_in)); endsequence
    sequence s_flushed; ##[1:2] (o_led_n && !o_pwm); endsequence
    property p_wake; !o_awake && !i_prog_mode && |i_switch_in |=> ##1 o_awake; endproperty
    a_wake: assert property (p_wake) else $error("no wake on press");
    property p_debounce; $rose(o_awake) |-> o_led_n [*8]; endproperty
    a_debounce: assert property (p_debounce) else $error("sent before debounce");
    property p_abort; s_added |-> s_flushed; endproperty
    a_abort: assert property (p_abort) else $error("word not abandoned");
    property p_prog_oe; !o_awake && i_prog_mode && i_switch_in == 4'h0 |=> ##1 !o_pwm_oe; endproperty
    a_prog_oe: assert property (p_prog_oe) else $error("pin driven in programming");
    property p_pwm_led; o_pwm_oe && o_pwm |-> !o_led_n; endproperty
    a_pwm_led: assert property (p_pwm_led) else $error("pulse without indicator");
    property p_tout_quiet; $past(o_timeout) && o_timeout |-> !o_pwm && o_led_n; endproperty
    a_tout_quiet: assert property (p_tout_quiet) else $error("sending in time-out");
    property p_tout_hold; o_timeout && |i_switch_in |=> o_timeout; endproperty
    a_tout_hold: assert property (p_tout_hold) else $error("time-out left early");
    property p_tout_exit; o_timeout && i_switch_in == 4'h0 |-> ##[1:2] !o_timeout; endproperty
    a_tout_exit: assert property (p_tout_exit) else $error("time-out stuck");
endmodule : hec_encoder_chk
bind hec_encoder hec_encoder_chk hec_encoder_chk_inst (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_switch_in(i_switch_in), .i_prog_mode(i_prog_mode), .o_pwm(o_pwm),
    .o_pwm_oe(o_pwm_oe), .o_led_n(o_led_n), .o_awake(o_awake), .o_timeout(o_timeout));

// ===== test/hec_rf_rx.sv
// Receiver model on the modulated output.
// Assumes ELEM core cycles per element; a long low gap ends a frame.
`timescale 1ns/100ps
module hec_rf_rx #(
    parameter int ELEM = 4
) (
    input wire logic i_core_clk,
    input wire logic i_pwm,
    output logic [65:0] o_word,
    output int o_nbits
);
    int hi_cnt = 0;
    int lo_cnt = 0;
    logic last_q = 1'b0;
    initial o_word = '0;
    initial o_nbits = 0;
    // Short high is a one; arrives LSB first so shift in at the top
    always @(posedge i_core_clk) begin
        last_q <= i_pwm;
        hi_cnt <= i_pwm ? hi_cnt + 1 : 0;
        lo_cnt <= i_pwm ? 0 : lo_cnt + 1;
        if (last_q && !i_pwm) begin
            o_word <= {hi_cnt < ELEM + ELEM / 2, o_word[65:1]};
            o_nbits <= o_nbits + 1;
        end else if (lo_cnt > 3 * ELEM) begin
            o_nbits <= 0;
        end
    end
endmodule : hec_rf_rx

// ===== test/hec_encoder_tb.sv
// Bench: programs the store, presses switches, decodes the words sent.
// Assumes shortened debounce, shutoff and element counts.
`timescale 1ns/100ps
module hec_encoder_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] sw = 4'h0;
    logic prog = 1'b0;
    logic pdat = 1'b0;
    logic lo6 = 1'b0;
    logic lo9 = 1'b0;
    logic ce = 1'b1;
    logic frz;
    logic pwm, oe, led_n, awake, tout;
    logic [65:0] word;
    logic [31:0] hop1;
    int rx_n;
    int error_cnt = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    hec_encoder #(.DEBOUNCE_CYCLES(32'd20), .SHUTOFF_CYCLES(40'd5000), .ELEM_SLOW_CYCLES(32'd4),
        .ELEM_MID_CYCLES(32'd2), .ELEM_FAST_CYCLES(32'd1)) hec_encoder_inst (.i_core_clk(clk),
        .i_rst_b(rst_b), .i_ce(ce), .i_switch_in(sw), .i_prog_mode(prog), .i_pwm(pdat),
        .i_supply_below_6v(lo6), .i_supply_below_9v(lo9), .o_pwm(pwm), .o_pwm_oe(oe),
        .o_led_n(led_n), .o_awake(awake), .o_timeout(tout));
    hec_rf_rx hec_rf_rx_inst (.i_core_clk(clk), .i_pwm(pwm), .o_word(word), .o_nbits(rx_n));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic prog_all(input logic [15:0] ser_hi, input logic [15:0] opt);
        logic [15:0] img [12];
        img = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h0000, 16'h0000, 16'h1234, ser_hi,
            16'hbeef, 16'hcafe, 16'h0000, opt};
        prog = 1'b1;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 192; i++) begin
            pdat = img[i / 16][i % 16];
            sw[3] = 1'b1;
            @(negedge clk);
            sw[3] = 1'b0;
            @(negedge clk);
        end
        prog = 1'b0;
        repeat (4) @(negedge clk);
    endtask : prog_all
    // Press, release once on air, take one decoded word, wait for standby
    task automatic press(input logic [3:0] b);
        sw = b;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 4000 && led_n !== 1'b0; k++) @(negedge clk);
        sw = 4'h0;
        for (int k = 0; k < 4000 && rx_n != 66; k++) @(negedge clk);
        chk("rx_bits", 32'(rx_n), 32'h42);
        hop1 = word[31:0] ^ hop1;
        for (int k = 0; k < 4000 && awake !== 1'b0; k++) @(negedge clk);
        chk("standby", {31'h0, awake}, 32'h0);
    endtask : press
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    // Tests need about 14k cycles; allow a wide margin
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        chk("led_idle", {31'h0, led_n}, 32'h1);
        prog_all(16'h0567, 16'h0000);
        lo9 = 1'b1;
        hop1 = 32'h0;
        press(4'h1);
        chk("fixed", word[63:32], {4'h1, 28'h5671234});
        chk("low_supply", {31'h0, word[65]}, 32'h0);
        $display("test clear word done");
        press(4'h1);
        chk("hop_change", {31'h0, hop1 == 32'h0}, 32'h0);
        $display("test hop change done");
        lo6 = 1'b1;
        press(4'hf);
        chk("learn", word[31:0], 32'hcafebeef);
        chk("low_supply", {31'h0, word[65]}, 32'h1);
        $display("test learn done");
        sw = 4'h1;
        for (int k = 0; k < 4000 && led_n !== 1'b0; k++) @(negedge clk);
        repeat (40) @(negedge clk);
        press(4'h3);
        chk("abort_btn", {28'h0, word[63:60]}, 32'h3);
        $display("test abort done");
        // Outer cipher on; trip select must pick the 9 V comparator
        prog_all(16'h0567, 16'h9000);
        lo9 = 1'b0;
        press(4'h1);
        chk("outer", {31'h0, word[63:32] != {4'h1, 28'h5671234}}, 32'h1);
        chk("trip_sel", {31'h0, word[65]}, 32'h0);
        $display("test outer done");
        prog_all(16'h8567, 16'h0000);
        sw = 4'h1;
        for (int k = 0; k < 4000 && led_n !== 1'b0; k++) @(negedge clk);
        // Enable low must freeze the word on air
        ce = 1'b0;
        frz = pwm;
        for (int k = 0; k < 20; k++) begin
            @(negedge clk);
            chk("freeze", {31'h0, pwm}, {31'h0, frz});
        end
        ce = 1'b1;
        for (int k = 0; k < 9000 && tout !== 1'b1; k++) @(negedge clk);
        chk("timeout", {31'h0, tout}, 32'h1);
        sw = 4'h0;
        repeat (8) @(negedge clk);
        chk("released", {30'h0, awake, tout}, 32'h0);
        $display("test shutoff done");
        complete_run();
    end
endmodule : hec_encoder_tb
